// >>> addr_gen_regs.svh
`ifndef ADDR_GEN_REGS_SVH
`define ADDR_GEN_REGS_SVH

// Register offsets on the plain register port
`define STACK_LIMIT_OFS       4'h0
`define TABLE_PAGE_OFS        4'h1
`define VIS_PAGE_OFS          4'h2
`define CPU_CONTROL_OFS       4'h3
`define STATUS_OFS            4'h4

// Field positions
`define TABLE_CFG_BIT         7
`define PROG_VIS_BIT          2

// Reset values
`define TABLE_PAGE_RST        8'h00
`define VIS_PAGE_RST          8'h00
`define CPU_CONTROL_RST       16'h0000
`define STACK_POINTER_RST     16'h0800

// Fixed stack floor
`define STACK_FLOOR           16'h0800

`endif

// >>> addr_gen_pkg.sv
package addr_gen_pkg;

   // Kind of program-space access being formed
   typedef enum logic [3:0] {
      acc_none  = 4'b0001,
      acc_fetch = 4'b0010,
      acc_table = 4'b0100,
      acc_remap = 4'b1000
   } access_kind_type;

   // Program-space request towards program memory
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        upper;
      logic [23:0] addr;
   } prog_req_type;

   // Stack access request from the pipeline
   typedef struct packed {
      logic        push;
      logic        pop;
      logic        use_sp;
      logic [15:0] ea;
   } stack_req_type;

endpackage

// >>> stack_check.sv
`timescale 1ns/1ps
`include "addr_gen_regs.svh"

module stack_check (
   // Limit and access
   input  wire logic [15:0]           i_limit,
   input  wire addr_gen_pkg::stack_req_type i_req,
   // Trap causes
   output logic                       o_overflow,
   output logic                       o_underflow
);
   import addr_gen_pkg::*;

   // Any stack address above the limit traps; one at the limit is allowed
   always_comb begin
      o_overflow  = i_req.use_sp && (i_req.ea > i_limit);
      o_underflow = i_req.use_sp && (i_req.ea < `STACK_FLOOR);
   end

endmodule

// >>> addr_gen.sv
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "addr_gen_regs.svh"

module addr_gen (
   // Clock and reset
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst,
   // Register port
   input  wire logic [3:0]             i_reg_addr,
   input  wire logic [15:0]            i_reg_wdata,
   input  wire logic                   i_reg_wr,
   input  wire logic                   i_reg_rd,
   output logic      [15:0]            o_reg_rdata,
   // Instruction fetch
   input  wire logic                   i_fetch,
   input  wire logic [22:0]            i_pc,
   // Data-side access
   input  wire logic                   i_table_rd,
   input  wire logic                   i_table_wr,
   input  wire logic                   i_table_upper,
   input  wire logic                   i_data_rd,
   input  wire logic                   i_data_wr,
   input  wire logic [15:0]            i_data_ea,
   // Stack operations
   input  wire addr_gen_pkg::stack_req_type i_stack,
   input  wire logic                   i_call_push,
   input  wire logic                   i_exc_push,
   input  wire logic [7:0]             i_status_low_byte,
   // Program memory side
   output addr_gen_pkg::prog_req_type  o_prog,
   output addr_gen_pkg::access_kind_type o_kind,
   output logic                        o_remap_low_only,
   output logic                        o_remap_wr_blocked,
   output logic                        o_table_cfg,
   output logic                        o_cfg_wr_blocked,
   // Stack pointer and stacked PC word
   output logic      [15:0]            o_stack_pointer_reg,
   output logic      [15:0]            o_stack_addr,
   output logic      [15:0]            o_stack_pc_hi,
   // Trap to exception logic
   output logic                        o_stack_trap
);
   import addr_gen_pkg::*;

   logic [15:0] stack_limit;
   logic [7:0]  table_page;
   logic [7:0]  visibility_page;
   logic [15:0] cpu_control;
   logic [15:0] stack_pointer_reg;
   logic [15:0] next_stack_pointer;
   logic        program_visibility;
   logic        table_active;
   logic        remap_hit;
   logic        overflow;
   logic        underflow;
   logic        trap_seen;
   logic        cfg_dropped;
   stack_req_type chk_req;

   assign program_visibility = cpu_control[`PROG_VIS_BIT];
   assign table_active       = i_table_rd | i_table_wr;
   // Remap needs the enable and no table access in flight
   assign remap_hit = i_data_ea[15] && program_visibility
                      && !table_active;

   // Limit register: no reset, bit 0 held low for word alignment
   always_ff @(posedge i_ref_clk) begin
      if (i_reg_wr && i_reg_addr == `STACK_LIMIT_OFS) begin
         stack_limit <= {i_reg_wdata[15:1], 1'b0};
      end
   end

   // Page registers and control
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         table_page      <= `TABLE_PAGE_RST;
         visibility_page <= `VIS_PAGE_RST;
         cpu_control     <= `CPU_CONTROL_RST;
      end else if (i_reg_wr) begin
         if (i_reg_addr == `TABLE_PAGE_OFS) begin
            table_page <= i_reg_wdata[7:0];
         end
         if (i_reg_addr == `VIS_PAGE_OFS) begin
            visibility_page <= i_reg_wdata[7:0];
         end
         if (i_reg_addr == `CPU_CONTROL_OFS) begin
            cpu_control <= i_reg_wdata;
         end
      end
   end

   // Stack pointer moves one word per push or pop
   always_comb begin
      next_stack_pointer = stack_pointer_reg;
      if (i_stack.push) begin
         next_stack_pointer = stack_pointer_reg + 16'h0002;
      end else if (i_stack.pop) begin
         next_stack_pointer = stack_pointer_reg - 16'h0002;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         stack_pointer_reg <= `STACK_POINTER_RST;
      end else begin
         stack_pointer_reg <= next_stack_pointer;
      end
   end

   // Push uses current pointer, pop the decremented one
   always_comb begin
      o_stack_addr = stack_pointer_reg;
      if (i_stack.pop) begin
         o_stack_addr = stack_pointer_reg - 16'h0002;
      end
   end

   // Upper stacked PC word: PC bits 22:16 for call, status byte above them for exception
   // Idle word is zero, so no stale PC bits leak onto the stack bus
   always_comb begin
      o_stack_pc_hi = 16'h0000;
      if (i_call_push) begin
         o_stack_pc_hi = {9'h000, i_pc[22:16]};
      end
      if (i_exc_push) begin
         o_stack_pc_hi = {i_status_low_byte, 1'b0, i_pc[22:16]};
      end
   end
   assign o_stack_pointer_reg = stack_pointer_reg;

   // Check either the explicit SP access or the internal push/pop address
   always_comb begin
      chk_req        = i_stack;
      chk_req.ea     = i_stack.use_sp ? i_stack.ea : o_stack_addr;
      chk_req.use_sp = i_stack.use_sp | i_stack.push | i_stack.pop;
   end

   stack_check u_check (
      .i_limit     (stack_limit),
      .i_req       (chk_req),
      .o_overflow  (overflow),
      .o_underflow (underflow)
   );

   // Combinational so the trap lands in the checked cycle
   assign o_stack_trap = overflow | underflow;

   // Program address formation, fetch has priority over data side
   always_comb begin
      o_prog             = '0;
      o_kind             = acc_none;
      o_remap_low_only   = 1'b0;
      o_remap_wr_blocked = 1'b0;
      o_cfg_wr_blocked   = 1'b0;
      o_table_cfg        = table_page[`TABLE_CFG_BIT];
      if (i_fetch) begin
         o_kind       = acc_fetch;
         o_prog.valid = 1'b1;
         o_prog.addr  = {1'b0, i_pc[22:1], 1'b0};
      end else if (table_active) begin
         o_kind       = acc_table;
         // Full 24-bit address, byte-granular EA low bit kept
         o_prog.addr  = {table_page, i_data_ea};
         o_prog.upper = i_table_upper;
         o_prog.write = i_table_wr;
         o_prog.valid = 1'b1;
         // Configuration space accepts reads only
         if (i_table_wr && table_page[`TABLE_CFG_BIT]) begin
            o_prog.valid     = 1'b0;
            o_prog.write     = 1'b0;
            o_cfg_wr_blocked = 1'b1;
         end
      end else if (remap_hit && (i_data_rd || i_data_wr)) begin
         o_kind           = acc_remap;
         o_remap_low_only = 1'b1;
         // Bit 23 zero, page supplies bits 22:15, EA bit 15 unused
         o_prog.addr = {1'b0, visibility_page,
                        i_data_ea[14:1], 1'b0};
         o_prog.valid = i_data_rd;
         o_remap_wr_blocked = i_data_wr;
      end
   end

   // Sticky diagnostics; a new event wins over a status read clear
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         trap_seen   <= 1'b0;
         cfg_dropped <= 1'b0;
      end else begin
         if (i_reg_rd && i_reg_addr == `STATUS_OFS) begin
            trap_seen   <= 1'b0;
            cfg_dropped <= 1'b0;
         end
         if (o_stack_trap) begin
            trap_seen <= 1'b1;
         end
         if (o_cfg_wr_blocked) begin
            cfg_dropped <= 1'b1;
         end
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            `STACK_LIMIT_OFS: o_reg_rdata <= stack_limit;
            `TABLE_PAGE_OFS:  o_reg_rdata <= {8'h00, table_page};
            `VIS_PAGE_OFS:    o_reg_rdata <= {8'h00, visibility_page};
            `CPU_CONTROL_OFS: o_reg_rdata <= cpu_control;
            `STATUS_OFS:      o_reg_rdata <= {14'h0000, cfg_dropped,
                                              trap_seen};
            default:          o_reg_rdata <= 16'h0000;
         endcase
      end else begin
         o_reg_rdata <= 16'h0000;
      end
   end

   // Limit write then SP indirect read in next cycle is software's job
   // (stack_limit is already updated at that point here)

endmodule

// >>> addr_gen_chk.sv
`timescale 1ns/1ps
module addr_gen_chk
   import addr_gen_pkg::*;
(
   // Clock, reset and watched pins
   input wire logic            i_ref_clk,
   input wire logic            i_rst,
   input wire logic            i_fetch,
   input wire logic [22:0]     i_pc,
   input wire logic            i_table_rd,
   input wire logic            i_table_wr,
   input wire logic [15:0]     i_data_ea,
   input wire stack_req_type   i_stack,
   input wire prog_req_type    o_prog,
   input wire access_kind_type o_kind,
   input wire logic            o_table_cfg,
   input wire logic            o_stack_trap
);
   // All paths are combinational, so checks hold in the same cycle
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   fetch_addr_a: assert property (
      i_fetch |-> o_kind == acc_fetch && o_prog.valid &&
      o_prog.addr == {1'b0, i_pc[22:1], 1'b0}) else $error("fetch addr");
   table_addr_a: assert property (
      !i_fetch && i_table_rd |-> o_kind == acc_table &&
      o_prog.addr[15:0] == i_data_ea) else $error("table addr");
   remap_user_a: assert property (
      o_kind == acc_remap |-> !o_prog.addr[23] && !o_prog.addr[0])
      else $error("remap user space");
   remap_addr_a: assert property (
      o_kind == acc_remap |-> i_data_ea[15] &&
      o_prog.addr[14:1] == i_data_ea[14:1]) else $error("remap addr");
   remap_hold_a: assert property (
      i_table_rd || i_table_wr |-> o_kind != acc_remap)
      else $error("remap during table");
   cfg_write_a: assert property (
      !i_fetch && i_table_wr && o_table_cfg |-> !o_prog.valid)
      else $error("config write passed");
   stack_floor_a: assert property (
      i_stack.use_sp && i_stack.ea < 16'h0800 |-> o_stack_trap)
      else $error("underflow missed");
   trap_cause_a: assert property (
      o_stack_trap |-> i_stack.push || i_stack.pop || i_stack.use_sp)
      else $error("trap without access");
endmodule

bind addr_gen addr_gen_chk u_addr_gen_chk (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_fetch(i_fetch), .i_pc(i_pc),
   .i_table_rd(i_table_rd), .i_table_wr(i_table_wr),
   .i_data_ea(i_data_ea), .i_stack(i_stack), .o_prog(o_prog),
   .o_kind(o_kind), .o_table_cfg(o_table_cfg), .o_stack_trap(o_stack_trap)
);

// >>> prog_mem_model.sv
`timescale 1ns/1ps
module prog_mem_model
   import addr_gen_pkg::*;
(
   // Request from the address generator
   input  wire logic         i_ref_clk,
   input  wire prog_req_type i_prog,
   // Writes that reached the array
   output int unsigned       o_write_count
);
   int unsigned write_count = 0;

   // Refused writes never raise both valid and write, so they never land here
   always @(posedge i_ref_clk) begin
      if (i_prog.valid && i_prog.write) begin
         write_count <= write_count + 1;
      end
   end
   assign o_write_count = write_count;
endmodule

// >>> addr_gen_tb.sv
`timescale 1ns/1ps
module addr_gen_tb;
   import addr_gen_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [3:0] ra = 4'h0;
   logic [15:0] wd = 16'h0000;
   logic [15:0] ea = 16'h0000;
   logic [22:0] pc = 23'h000000;
   logic [7:0] stb = 8'h00;
   logic wr = 1'b0, rd = 1'b0, fe = 1'b0, trd = 1'b0, twr = 1'b0;
   logic tup = 1'b0, drd = 1'b0, dwr = 1'b0, cp = 1'b0, ep = 1'b0;
   stack_req_type stk = '0;
   logic [15:0] rdata, sp, sadr, pchi;
   prog_req_type prog;
   access_kind_type kind;
   logic lowo, rwb, cfg, cwb, trap;
   int unsigned wcount;
   int fails = 0;
   int comparisons = 0;

   // Free-running core clock
   always #10 i_ref_clk = ~i_ref_clk;

   addr_gen u_addr_gen (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(ra),
      .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_fetch(fe), .i_pc(pc), .i_table_rd(trd), .i_table_wr(twr),
      .i_table_upper(tup), .i_data_rd(drd), .i_data_wr(dwr),
      .i_data_ea(ea), .i_stack(stk), .i_call_push(cp), .i_exc_push(ep),
      .i_status_low_byte(stb), .o_prog(prog), .o_kind(kind),
      .o_remap_low_only(lowo), .o_remap_wr_blocked(rwb),
      .o_table_cfg(cfg), .o_cfg_wr_blocked(cwb),
      .o_stack_pointer_reg(sp), .o_stack_addr(sadr),
      .o_stack_pc_hi(pchi), .o_stack_trap(trap));
   prog_mem_model u_prog_mem_model (
      .i_ref_clk(i_ref_clk), .i_prog(prog), .o_write_count(wcount));

   // Compare and count
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge i_ref_clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_ref_clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge i_ref_clk);
      rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
   endtask
   task automatic stack_op(input logic [2:0] c, input logic [15:0] a,
                           input logic [15:0] e_adr, input logic e_trap);
      @(posedge i_ref_clk);
      stk <= {c, a};
      #1 chk({trap, sadr}, {e_trap, e_adr});
      @(posedge i_ref_clk);
      stk <= '0;
   endtask
   task automatic complete_run;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      reg_rd(4'h1, 16'h0000);
      reg_rd(4'h9, 16'h0000);
      reg_wr(4'h0, 16'h0901);
      reg_rd(4'h0, 16'h0900);
      reg_wr(4'h1, 16'h0083);
      @(posedge i_ref_clk);
      trd <= 1'b1;
      tup <= 1'b1;
      ea <= 16'h1235;
      #1 chk(prog.addr, 24'h831235);
      chk({cfg, prog.upper, prog.valid}, 3'b111);
      @(posedge i_ref_clk);
      trd <= 1'b0;
      twr <= 1'b1;
      #1 chk({cwb, prog.valid}, 2'b10);
      reg_wr(4'h1, 16'h0003);
      #1 chk({cwb, prog.valid, prog.write}, 3'b011);
      @(posedge i_ref_clk);
      twr <= 1'b0;
      reg_wr(4'h2, 16'h0035);
      reg_wr(4'h3, 16'h0004);
      drd <= 1'b1;
      ea <= 16'h8abd;
      #1 chk(prog.addr, 24'h1a8abc);
      chk({lowo, kind}, {1'b1, acc_remap});
      @(posedge i_ref_clk);
      trd <= 1'b1;
      #1 chk(kind, acc_table);
      @(posedge i_ref_clk);
      trd <= 1'b0;
      drd <= 1'b0;
      dwr <= 1'b1;
      #1 chk({rwb, prog.valid}, 2'b10);
      @(posedge i_ref_clk);
      dwr <= 1'b0;
      drd <= 1'b1;
      reg_wr(4'h3, 16'h0000);
      #1 chk(kind, acc_none);
      @(posedge i_ref_clk);
      fe <= 1'b1;
      pc <= 23'h5abcdf;
      #1 chk(prog.addr, 24'h5abcde);
      chk(kind, acc_fetch);
      @(posedge i_ref_clk);
      fe <= 1'b0;
      drd <= 1'b0;
      cp <= 1'b1;
      pc <= 23'h7f0123;
      #1 chk(pchi, 16'h007f);
      @(posedge i_ref_clk);
      cp <= 1'b0;
      ep <= 1'b1;
      stb <= 8'ha5;
      #1 chk(pchi, 16'ha57f);
      chk(wcount[23:0], 24'h000001);
      @(posedge i_ref_clk);
      ep <= 1'b0;
      reg_wr(4'h0, 16'h0802);
      reg_rd(4'h0, 16'h0802);
      stack_op(3'b100, 16'h0000, 16'h0800, 1'b0);
      #1 chk(sp, 24'h000802);
      stack_op(3'b100, 16'h0000, 16'h0802, 1'b0);
      stack_op(3'b100, 16'h0000, 16'h0804, 1'b1);
      #1 chk(trap, 1'b0);
      stack_op(3'b010, 16'h0000, 16'h0804, 1'b1);
      reg_rd(4'h4, 16'h0003);
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      @(posedge i_ref_clk);
      i_rst <= 1'b0;
      #1 chk(sp, 24'h000800);
      reg_rd(4'h2, 16'h0000);
      stack_op(3'b011, 16'h07fe, 16'h07fe, 1'b1);
      reg_rd(4'h4, 16'h0001);
      reg_rd(4'h4, 16'h0000);
      complete_run();
   end
endmodule
